/* File: core/nfc_map.svh */
// Constants of the NAND flash host controller: commands, geometry, address layout and timing.
// What this block does
// - Host drives the four unused upper bits of column cycle two low.
// - Bytes are written by pulsing write strobe low with chip select low.
// - Command latch marks command bytes, address latch marks address bytes.
// - Reset and read status are single-byte commands; read identifier adds one address byte.
// - Read, program and erase need setup, address and confirm bytes.
// - Random column change: 85h for input, 05h then E0h for output.
// - Cache read uses 31h and 3Fh; cache program uses 80h then 15h.
// - Host refuses program, copy-back program, cache program and erase requests to blocks already marked bad.
`ifndef NFC_MAP_SVH
`define NFC_MAP_SVH

`define NFC_CMD_READ        8'h00
`define NFC_CMD_READ_GO     8'h30
`define NFC_CMD_READ_CB_GO  8'h35
`define NFC_CMD_READ_ID     8'h90
`define NFC_CMD_RESET       8'hff
`define NFC_CMD_PROG        8'h80
`define NFC_CMD_PROG_GO     8'h10
`define NFC_CMD_CACHE_GO    8'h15
`define NFC_CMD_COPY_PROG   8'h85
`define NFC_CMD_ERASE       8'h60
`define NFC_CMD_ERASE_GO    8'hd0
`define NFC_CMD_RAND_OUT    8'h05
`define NFC_CMD_RAND_OUT_GO 8'he0
`define NFC_CMD_STATUS      8'h70
`define NFC_CMD_CACHE_NEXT  8'h31
`define NFC_CMD_CACHE_LAST  8'h3f

`define NFC_PAGE_BYTES      2112
`define NFC_SPARE_START     2048
`define NFC_BLOCKS          1024
`define NFC_BLK_LSB         6
`define NFC_COL_W           12
`define NFC_ROW_W           16
`define NFC_ADDR_CYCLES     4
`define NFC_ADDR_ROW_FIRST  2
`define NFC_FIFO_DEPTH      32

`define NFC_CLK_MHZ         40
`define NFC_T_ADL_NS        100
`define NFC_T_WB_NS         100
`define NFC_T_RR_NS         20
`define NFC_T_ADL_CYC       (((`NFC_T_ADL_NS) * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_WB_CYC        (((`NFC_T_WB_NS) * `NFC_CLK_MHZ + 999) / 1000)
`define NFC_T_RR_CYC        (((`NFC_T_RR_NS) * `NFC_CLK_MHZ + 999) / 1000)

`endif

/* File: core/nfc_pkg.sv */
// Types shared by the NAND flash host controller.
package nfc_pkg;
  `include "nfc_map.svh"

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_CMD1 = 7'h02, ST_ADDR = 7'h04, ST_DIN = 7'h08,
    ST_CMD2 = 7'h10, ST_WAIT = 7'h20, ST_DOUT = 7'h40
  } nfc_state_e;

  typedef enum logic [3:0] {
    OP_RESET, OP_STATUS, OP_READ_ID, OP_READ, OP_READ_CB, OP_PROG, OP_PROG_CB,
    OP_CACHE_PROG, OP_ERASE, OP_RAND_IN, OP_RAND_OUT, OP_CACHE_NEXT, OP_CACHE_LAST,
    OP_CONFIRM
  } nfc_op_e;

  // One request from the user side.
  typedef struct packed {
    nfc_op_e                op;
    logic [`NFC_COL_W-1:0]  col;
    logic [`NFC_ROW_W-1:0]  row;
    logic [11:0]            len;
  } nfc_req_s;

  // Shape of one flash operation on the pins.
  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic       has_c2;
    logic [2:0] naddr;
    logic [1:0] first;
    logic       din;
    logic       dout;
    logic       wait_rb;
  } nfc_desc_s;
endpackage : nfc_pkg

/* File: core/nfc_host.sv */
// NAND flash host controller with its write-data FIFO.
`include "nfc_map.svh"
module nfc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Filling side.
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Draining side.
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          in_ready;
    logic          out_valid;
  } nfc_fifo_st_s;

  nfc_fifo_st_s s_ff;
  nfc_fifo_st_s nxt_s;
  logic [W-1:0] mem [D];
  logic         push;
  logic         pop;

  // Flags are registered so the ready seen by the source is a flip-flop.
  always_comb begin
    push  = in_valid && s_ff.in_ready;
    pop   = s_ff.out_valid && out_ready;
    nxt_s = s_ff;
    if (push) begin
      nxt_s.wr_ptr = (s_ff.wr_ptr == AW'(D - 1)) ? '0 : s_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd_ptr = (s_ff.rd_ptr == AW'(D - 1)) ? '0 : s_ff.rd_ptr + 1'b1;
    end
    nxt_s.count     = s_ff.count + (AW+1)'(push) - (AW+1)'(pop);
    nxt_s.in_ready  = nxt_s.count < (AW+1)'(D);
    nxt_s.out_valid = nxt_s.count != '0;
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Storage array.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_ff.wr_ptr] <= in_data;
    end
  end

  assign in_ready  = s_ff.in_ready;
  assign out_valid = s_ff.out_valid;
  assign out_data  = mem[s_ff.rd_ptr];
endmodule : nfc_fifo

module nfc_host
  import nfc_pkg::*;
#(
  parameter int FIFO_DEPTH = `NFC_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Request port.
  input  wire logic       cmd_valid,
  input  nfc_req_s        cmd,
  output logic            cmd_ready,
  output logic            done,
  output logic            err,
  // Program data in and read data out.
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  // Bad block marking and write permission.
  input  wire logic       mark_valid,
  input  wire logic [9:0] mark_block,
  input  wire logic       wr_allow,
  // Flash pins.
  output logic            ce_n,
  output logic            cle,
  output logic            ale,
  output logic            we_n,
  output logic            read_strobe_n,
  output logic            wp_n,
  output logic [7:0]      data_pins_out,
  output logic            data_pins_oe,
  input  wire logic [7:0] data_pins_in,
  input  wire logic       rb_in
);
  typedef struct packed {
    nfc_state_e  state;
    logic        ph;
    nfc_req_s    req;
    nfc_desc_s   desc;
    logic [1:0]  idx;
    logic [11:0] left;
    logic [2:0]  gap;
    logic        ce_n, cle, ale, we_n, rd_n, wp_n;
    logic [7:0]  dq_out;
    logic        dq_oe;
    logic        cmd_ready, done, err, rd_valid;
    logic [7:0]  rd_data;
  } nfc_st_s;

  nfc_st_s          s_ff;
  nfc_st_s          nxt_s;
  nfc_desc_s        dsc;
  logic [`NFC_BLOCKS-1:0] bad_ff;
  logic             f_valid;
  logic [7:0]       f_data;
  logic             f_pop;
  logic [12:0]      room;
  nfc_state_e       post_c2;
  nfc_state_e       post_addr;

  // Shape of each operation: command bytes, address cycles, data and busy wait.
  function automatic nfc_desc_s op_desc(input nfc_op_e op);
    nfc_desc_s d;
    d = '{c1: `NFC_CMD_RESET, c2: 8'h00, has_c2: 1'b0, naddr: 3'h0, first: 2'h0,
          din: 1'b0, dout: 1'b0, wait_rb: 1'b0};
    case (op)
      OP_RESET:      d.wait_rb = 1'b1;
      OP_STATUS:     begin d.c1 = `NFC_CMD_STATUS; d.dout = 1'b1; end
      OP_READ_ID:    begin d.c1 = `NFC_CMD_READ_ID; d.naddr = 3'h1; d.dout = 1'b1; end
      OP_READ:       d = '{`NFC_CMD_READ, `NFC_CMD_READ_GO, 1'b1, 3'h4, 2'h0,
                           1'b0, 1'b1, 1'b1};
      OP_READ_CB:    d = '{`NFC_CMD_READ, `NFC_CMD_READ_CB_GO, 1'b1, 3'h4, 2'h0,
                           1'b0, 1'b0, 1'b1};
      OP_PROG:       d = '{`NFC_CMD_PROG, `NFC_CMD_PROG_GO, 1'b1, 3'h4, 2'h0,
                           1'b1, 1'b0, 1'b1};
      OP_PROG_CB:    d = '{`NFC_CMD_COPY_PROG, `NFC_CMD_PROG_GO, 1'b1, 3'h4, 2'h0,
                           1'b0, 1'b0, 1'b1};
      OP_CACHE_PROG: d = '{`NFC_CMD_PROG, `NFC_CMD_CACHE_GO, 1'b1, 3'h4, 2'h0,
                           1'b1, 1'b0, 1'b1};
      OP_ERASE:      d = '{`NFC_CMD_ERASE, `NFC_CMD_ERASE_GO, 1'b1, 3'h2,
                           2'(`NFC_ADDR_ROW_FIRST), 1'b0, 1'b0, 1'b1};
      OP_RAND_IN:    d = '{`NFC_CMD_COPY_PROG, 8'h00, 1'b0, 3'h2, 2'h0,
                           1'b1, 1'b0, 1'b0};
      OP_RAND_OUT:   d = '{`NFC_CMD_RAND_OUT, `NFC_CMD_RAND_OUT_GO, 1'b1, 3'h2, 2'h0,
                           1'b0, 1'b1, 1'b0};
      OP_CACHE_NEXT: d = '{`NFC_CMD_CACHE_NEXT, 8'h00, 1'b0, 3'h0, 2'h0,
                           1'b0, 1'b1, 1'b1};
      OP_CACHE_LAST: d = '{`NFC_CMD_CACHE_LAST, 8'h00, 1'b0, 3'h0, 2'h0,
                           1'b0, 1'b1, 1'b1};
      OP_CONFIRM:    d = '{`NFC_CMD_PROG_GO, 8'h00, 1'b0, 3'h0, 2'h0,
                           1'b0, 1'b0, 1'b1};
      default:       d.wait_rb = 1'b1;
    endcase
    return d;
  endfunction : op_desc

  // Byte carried by each of the four address cycles, least significant first.
  function automatic logic [7:0] addr_byte(input logic [1:0] i, input nfc_req_s r);
    case (i)
      2'h0:    return r.col[7:0];
      2'h1:    return {4'h0, r.col[11:8]};
      2'h2:    return r.row[7:0];
      default: return r.row[15:8];
    endcase
  endfunction : addr_byte

  // Operations that change the array and so must avoid bad blocks.
  function automatic logic is_write(input nfc_op_e op);
    return op == OP_PROG || op == OP_PROG_CB || op == OP_CACHE_PROG || op == OP_ERASE;
  endfunction : is_write

  // Program data passes through the FIFO; an empty FIFO stalls the write strobes.
  nfc_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  // Bad block table filled by the user side.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_ff <= '0;
    end else if (mark_valid) begin
      bad_ff[mark_block] <= 1'b1;
    end
  end

  // Sequencer: every pin strobe is one cycle low and one cycle high.
  always_comb begin
    nxt_s      = s_ff;
    dsc        = op_desc(cmd.op);
    f_pop      = 1'b0;
    room       = 13'(`NFC_PAGE_BYTES) - {1'b0, s_ff.req.col};
    post_c2    = s_ff.desc.wait_rb ? ST_WAIT : (s_ff.desc.dout ? ST_DOUT : ST_IDLE);
    post_addr  = s_ff.desc.din ? ST_DIN : (s_ff.desc.has_c2 ? ST_CMD2 : post_c2);
    nxt_s.done     = 1'b0;
    nxt_s.err      = 1'b0;
    nxt_s.rd_valid = 1'b0;
    nxt_s.wp_n     = wr_allow;
    case (s_ff.state)
      ST_IDLE: begin
        if (cmd_valid && s_ff.cmd_ready) begin
          if ((!rb_in && cmd.op != OP_RESET && cmd.op != OP_STATUS) ||
              (is_write(cmd.op) && bad_ff[cmd.row[15:`NFC_BLK_LSB]])) begin
            nxt_s.err  = 1'b1;
            nxt_s.done = 1'b1;
          end else begin
            nxt_s.req       = cmd;
            nxt_s.desc      = dsc;
            nxt_s.idx       = dsc.first;
            nxt_s.cmd_ready = 1'b0;
            nxt_s.ce_n      = 1'b0;
            nxt_s.ph        = 1'b0;
            nxt_s.state     = ST_CMD1;
          end
        end
      end
      ST_CMD1, ST_CMD2: begin
        if (!s_ff.ph) begin
          nxt_s.we_n   = 1'b0;
          nxt_s.cle    = 1'b1;
          nxt_s.ale    = 1'b0;
          nxt_s.dq_out = (s_ff.state == ST_CMD1) ? s_ff.desc.c1 : s_ff.desc.c2;
          nxt_s.dq_oe  = 1'b1;
          nxt_s.ph     = 1'b1;
        end else begin
          nxt_s.we_n  = 1'b1;
          nxt_s.ph    = 1'b0;
          nxt_s.left  = (room[12] || room == '0) ? 12'h000 :
                        ({1'b0, s_ff.req.len} > room) ? room[11:0] : s_ff.req.len;
          if (s_ff.state == ST_CMD2) begin
            nxt_s.state = post_c2;
          end else if (s_ff.desc.naddr != 3'h0) begin
            nxt_s.state = ST_ADDR;
          end else begin
            nxt_s.state = post_addr;
          end
        end
      end
      ST_ADDR: begin
        if (!s_ff.ph) begin
          nxt_s.we_n   = 1'b0;
          nxt_s.cle    = 1'b0;
          nxt_s.ale    = 1'b1;
          nxt_s.dq_out = addr_byte(s_ff.idx, s_ff.req);
          nxt_s.ph     = 1'b1;
        end else begin
          nxt_s.we_n  = 1'b1;
          nxt_s.ph    = 1'b0;
          nxt_s.idx   = s_ff.idx + 2'h1;
          nxt_s.desc.naddr = s_ff.desc.naddr - 3'h1;
          if (s_ff.desc.naddr == 3'h1) begin
            nxt_s.state = post_addr;
          end
        end
      end
      ST_DIN: begin
        if (s_ff.gap != 3'h0) begin
          nxt_s.gap = s_ff.gap - 3'h1;
        end else if (!s_ff.ph) begin
          if (s_ff.left == 12'h000) begin
            nxt_s.state = s_ff.desc.has_c2 ? ST_CMD2 : post_c2;
          end else if (f_valid) begin
            f_pop        = 1'b1;
            nxt_s.we_n   = 1'b0;
            nxt_s.cle    = 1'b0;
            nxt_s.ale    = 1'b0;
            nxt_s.dq_out = f_data;
            nxt_s.ph     = 1'b1;
          end
        end else begin
          nxt_s.we_n = 1'b1;
          nxt_s.ph   = 1'b0;
          nxt_s.left = s_ff.left - 12'h001;
        end
      end
      ST_WAIT: begin
        if (s_ff.gap != 3'h0) begin
          nxt_s.gap = s_ff.gap - 3'h1;
        end else if (rb_in) begin
          nxt_s.state = s_ff.desc.dout ? ST_DOUT : ST_IDLE;
        end
      end
      ST_DOUT: begin
        if (s_ff.gap != 3'h0) begin
          nxt_s.gap   = s_ff.gap - 3'h1;
          nxt_s.cle   = 1'b0; // Latches drop one edge after entry here: after the last write strobe rise, or after the busy wait when one came between.
          nxt_s.ale   = 1'b0;
          nxt_s.dq_oe = 1'b0;
        end else if (!s_ff.ph) begin
          if (s_ff.left == 12'h000) begin
            nxt_s.state = ST_IDLE;
          end else begin
            nxt_s.rd_n = 1'b0;
            nxt_s.ph   = 1'b1;
          end
        end else begin
          nxt_s.rd_n     = 1'b1;
          nxt_s.ph       = 1'b0;
          nxt_s.rd_valid = 1'b1;
          nxt_s.rd_data  = data_pins_in;
          nxt_s.left     = s_ff.left - 12'h001;
        end
      end
      default: nxt_s.state = ST_IDLE;
    endcase
    // Entry actions: spacing before data or busy sampling, and release at the end.
    if (nxt_s.state != s_ff.state) begin
      if (nxt_s.state == ST_WAIT) begin
        nxt_s.gap = 3'(`NFC_T_WB_CYC);
      end else if (nxt_s.state == ST_DIN || nxt_s.state == ST_DOUT) begin
        nxt_s.gap = (s_ff.state == ST_WAIT) ? 3'(`NFC_T_RR_CYC) : 3'(`NFC_T_ADL_CYC);
      end
      if (nxt_s.state == ST_IDLE && s_ff.state != ST_IDLE) begin
        nxt_s.ce_n      = 1'b1;
        nxt_s.cle       = 1'b0;
        nxt_s.ale       = 1'b0;
        nxt_s.dq_oe     = 1'b0;
        nxt_s.cmd_ready = 1'b1;
        nxt_s.done      = 1'b1;
      end
    end
  end

  // State register with pins idle after reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff           <= '0;
      s_ff.state     <= ST_IDLE;
      s_ff.ce_n      <= 1'b1;
      s_ff.we_n      <= 1'b1;
      s_ff.rd_n      <= 1'b1;
      s_ff.cmd_ready <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register.
  assign cmd_ready     = s_ff.cmd_ready;
  assign done          = s_ff.done;
  assign err           = s_ff.err;
  assign rd_valid      = s_ff.rd_valid;
  assign rd_data       = s_ff.rd_data;
  assign ce_n          = s_ff.ce_n;
  assign cle           = s_ff.cle;
  assign ale           = s_ff.ale;
  assign we_n          = s_ff.we_n;
  assign read_strobe_n = s_ff.rd_n;
  assign wp_n          = s_ff.wp_n;
  assign data_pins_out = s_ff.dq_out;
  assign data_pins_oe  = s_ff.dq_oe;
endmodule : nfc_host

/* File: testbench/nfc_host_assertions.sv */
// Concurrent checks on the controller's flash pins and request port.
module nfc_host_assertions
  import nfc_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  // Clock, reset and requests.
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       cmd_valid,
  input wire nfc_req_s   cmd,
  input wire logic       cmd_ready,
  input wire logic       done,
  input wire logic       err,
  // Read data and write permission.
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic       wr_allow,
  // Flash pins.
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       read_strobe_n,
  input wire logic       wp_n,
  input wire logic [7:0] data_pins_out,
  input wire logic       data_pins_oe,
  input wire logic [7:0] data_pins_in,
  input wire logic       rb_in
);
  logic [2:0] acnt_ff;

  // Counts address bytes since the last command; erase begins at the row bytes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acnt_ff <= 3'h0;
    end else if (!we_n && cle) begin
      acnt_ff <= (data_pins_out == 8'h60) ? 3'h2 : 3'h0;
    end else if (!we_n && ale && acnt_ff != 3'h7) begin
      acnt_ff <= acnt_ff + 3'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Pin relations and request answers.
  a_write_framing: assert property (!we_n |-> !ce_n && data_pins_oe)
    else $error("write strobe without select or drive");
  a_latch_exclusive: assert property (!we_n |-> !(cle && ale))
    else $error("command and address latch both high");
  a_we_one_cycle: assert property ($fell(we_n) |=> we_n)
    else $error("write strobe low longer than one cycle");
  a_read_quiet: assert property (!read_strobe_n |->
    we_n && !data_pins_oe && !cle && !ale && !ce_n)
    else $error("read strobe low while bus is driven");
  a_col_upper_low: assert property (!we_n && ale && acnt_ff == 3'h1 |->
    data_pins_out[7:4] == 4'h0)
    else $error("upper column bits not low");
  a_addr_data_gap: assert property (!we_n && ale |=> (we_n || cle || ale) [*3])
    else $error("data byte too soon after address");
  a_wp_mirror: assert property ($past(rst_n) |-> wp_n == $past(wr_allow))
    else $error("write protect does not follow permission");
  a_busy_refusal: assert property (cmd_valid && cmd_ready && !rb_in &&
    !(cmd.op inside {OP_RESET, OP_STATUS}) |=> done && err)
    else $error("request taken while flash busy");
  a_read_capture: assert property ($rose(read_strobe_n) |->
    rd_valid && rd_data == $past(data_pins_in))
    else $error("read byte not captured at strobe rise");
  a_err_with_done: assert property (err |-> done && cmd_ready)
    else $error("refusal without completion");

  // Main scenarios.
  c_read_byte: cover property ($rose(read_strobe_n));
  c_refusal: cover property (done && err);
  c_erase_go: cover property (!we_n && cle && data_pins_out == 8'hd0);
endmodule : nfc_host_assertions

/* File: testbench/nfc_flash_model.sv */
// Behavioural NAND flash device that answers the controller's pins.
module nfc_flash_model #(
  parameter int          BUSY_CYC = 20,
  parameter logic [39:0] ID_BYTES = 40'h11_22_33_44_55 // Arbitrary identifier value.
) (
  // Clock and forced busy from the bench.
  input  wire logic       clk,
  input  wire logic       extra_busy,
  // Flash pins.
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] data_pins,
  output logic      [7:0] dq_drv,
  output logic            rb
);
  logic [7:0] mem [int];
  logic [7:0] pg [2112];
  logic [7:0] ad [4];
  logic [7:0] last_cmd = 8'h00;
  int         acnt = 0;
  int         col = 0;
  int         idx = 0;
  int         busy_left = 0;
  logic       rdy;

  assign rdy = (busy_left == 0) && !extra_busy;

  // Moves the page register to or from the addressed page; absent bytes read as erased.
  task automatic page_io(input bit store);
    int base;
    base = {ad[3], ad[2]} * 2112;
    for (int i = 0; i < 2112; i++) begin
      if (store) mem[base + i] = pg[i];
      else pg[i] = mem.exists(base + i) ? mem[base + i] : 8'hff;
    end
  endtask : page_io

  // Captures command, address and data bytes on the rising write strobe.
  always @(posedge we_n) begin
    int k;
    if (!ce_n && cle && (rdy || data_pins inside {8'hff, 8'h70})) begin
      last_cmd = data_pins;
      acnt = (data_pins == 8'h60) ? 2 : 0;
      idx = 0;
      if (data_pins == 8'h80) pg = '{default: 8'hff};
      if (data_pins inside {8'h31, 8'h3f}) {ad[3], ad[2]} = {ad[3], ad[2]} + 16'h1;
      if (data_pins inside {8'h30, 8'h35, 8'h31, 8'h3f}) page_io(1'b0);
      if (wp_n && data_pins inside {8'h10, 8'h15}) page_io(1'b1);
      if (wp_n && data_pins == 8'hd0) begin
        for (int i = 0; i < 64 * 2112; i++) begin
          k = {ad[3], ad[2][7:6], 6'h00} * 2112 + i;
          if (mem.exists(k)) mem.delete(k);
        end
      end
      if (data_pins inside {8'h30, 8'h35, 8'h31, 8'h3f, 8'h10, 8'h15, 8'hd0, 8'hff}) begin
        busy_left = BUSY_CYC;
      end
    end else if (!ce_n && ale && acnt < 4) begin
      ad[acnt] = data_pins;
      acnt++;
      col = {ad[1][3:0], ad[0]};
    end else if (!ce_n && !cle && !ale && col < 2112) begin
      pg[col] = data_pins;
      col++;
    end
  end

  // Each falling read strobe presents the next byte; a released bus shows the inverse.
  always @(negedge read_strobe_n) begin
    if (!ce_n && last_cmd == 8'h70) begin
      dq_drv = {wp_n, rdy, rdy, 5'h00};
    end else if (!ce_n && last_cmd == 8'h90) begin
      dq_drv = ID_BYTES[39 - 8 * idx -: 8];
      idx++;
    end else if (!ce_n) begin
      dq_drv = (col < 2112) ? pg[col] : 8'hff;
      col++;
    end
  end
  always @(posedge read_strobe_n) #5 dq_drv = ~dq_drv;

  // Busy counts down on the clock and ignores chip select meanwhile.
  always @(posedge clk) begin
    if (busy_left > 0) busy_left--;
    rb <= rdy;
  end
  initial dq_drv = 8'h00;
  initial rb = 1'b1;
endmodule : nfc_flash_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the NAND flash host controller against a device model.
module tb_top
  import nfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [39:0] ID_BYTES = 40'h3c_a5_5a_c3_0f; // Arbitrary identifier value.
  localparam logic [15:0] PAGE_A = 16'h0041;
  localparam logic [15:0] PAGE_B = 16'h0082;
  logic       clk, rst_n, cmd_valid, wr_valid, mark_valid, wr_allow, extra_busy;
  logic       cmd_ready, done, err, wr_ready, rd_valid, ce_n, cle, ale, we_n;
  logic       read_strobe_n, wp_n, data_pins_oe, rb;
  logic [7:0] wr_data, rd_data, data_pins_out, dq_drv, dq_bus;
  logic [9:0] mark_block;
  nfc_req_s   cmd;
  logic [7:0] rdq[$];
  int         error_cnt = 0;
  int         tests_run = 0;

  // The shared data wire follows whichever side drives it.
  assign dq_bus = data_pins_oe ? data_pins_out : dq_drv;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);

  nfc_host #(.FIFO_DEPTH(32)) u_nfc_host (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .done(done), .err(err), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .mark_valid(mark_valid), .mark_block(mark_block),
    .wr_allow(wr_allow), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .data_pins_out(data_pins_out),
    .data_pins_oe(data_pins_oe), .data_pins_in(dq_bus), .rb_in(rb));
  nfc_flash_model #(.BUSY_CYC(20), .ID_BYTES(ID_BYTES)) u_nfc_flash_model (
    .clk(clk), .extra_busy(extra_busy), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .data_pins(dq_bus), .dq_drv(dq_drv), .rb(rb));

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Issues one request and waits for its completion pulse.
  task automatic run_op(input nfc_op_e op, input logic [15:0] row, input logic [11:0] col,
                        input logic [11:0] len, input logic exp_err);
    int n = 0;
    rdq.delete();
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 100) begin @(negedge clk); n++; end
    cmd_valid = 1'b1;
    cmd = '{op: op, col: col, row: row, len: len};
    @(negedge clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    check("done", 8'h01, {7'h0, done});
    check("err", {7'h0, exp_err}, {7'h0, err});
  endtask : run_op

  task automatic check_rd(input int cnt, input logic [7:0] base, input logic [7:0] step);
    check("read count", 8'(cnt), 8'(rdq.size()));
    for (int i = 0; i < cnt; i++) check("read byte", base + step * 8'(i), rdq[i]);
  endtask : check_rd

  task automatic t_basic();
    check("ce_n", 8'h01, {7'h0, ce_n});
    wr_allow = 1'b0;
    repeat (2) @(negedge clk);
    check("wp_n", 8'h00, {7'h0, wp_n});
    wr_allow = 1'b1;
    run_op(OP_STATUS, 16'h0, 12'h0, 12'h001, 1'b0);
    check("status", 8'he0, rdq[0]);
    run_op(OP_READ_ID, 16'h0, 12'h0, 12'h005, 1'b0);
    for (int i = 0; i < 5; i++) check("id", ID_BYTES[39 - 8 * i -: 8], rdq[i]);
    $display("test basic finished");
  endtask : t_basic

  task automatic t_prog_read();
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      wr_valid = 1'b1;
      wr_data = 8'h40 + 8'(i);
    end
    @(negedge clk);
    wr_valid = 1'b0;
    check("wr_ready full", 8'h00, {7'h0, wr_ready});
    run_op(OP_PROG, PAGE_A, 12'h820, 12'h020, 1'b0);
    check("wr_ready drained", 8'h01, {7'h0, wr_ready});
    run_op(OP_READ, PAGE_A, 12'h820, 12'h028, 1'b0);
    check_rd(32, 8'h40, 8'h01);
    run_op(OP_RAND_OUT, PAGE_A, 12'h834, 12'h003, 1'b0);
    check_rd(3, 8'h54, 8'h01);
    $display("test program and read finished");
  endtask : t_prog_read

  task automatic t_copy_erase();
    run_op(OP_READ_CB, PAGE_A, 12'h0, 12'h0, 1'b0);
    run_op(OP_PROG_CB, PAGE_B, 12'h0, 12'h0, 1'b0);
    run_op(OP_READ, PAGE_B, 12'h820, 12'h004, 1'b0);
    check_rd(4, 8'h40, 8'h01);
    run_op(OP_ERASE, PAGE_B, 12'h0, 12'h0, 1'b0);
    run_op(OP_READ, PAGE_B, 12'h820, 12'h002, 1'b0);
    check_rd(2, 8'hff, 8'h00);
    mark_valid = 1'b1;
    mark_block = PAGE_A[15:6];
    @(negedge clk);
    mark_valid = 1'b0;
    run_op(OP_PROG, PAGE_A, 12'h0, 12'h0, 1'b1);
    run_op(OP_ERASE, PAGE_A, 12'h0, 12'h0, 1'b1);
    run_op(OP_READ, PAGE_A, 12'h820, 12'h001, 1'b0);
    check_rd(1, 8'h40, 8'h01);
    $display("test copy and erase finished");
  endtask : t_copy_erase

  task automatic t_busy();
    extra_busy = 1'b1;
    repeat (3) @(negedge clk);
    run_op(OP_READ, PAGE_A, 12'h0, 12'h001, 1'b1);
    run_op(OP_STATUS, 16'h0, 12'h0, 12'h001, 1'b0);
    check("busy status", 8'h80, rdq[0]);
    extra_busy = 1'b0;
    repeat (3) @(negedge clk);
    $display("test busy finished");
  endtask : t_busy

  task automatic t_codes();
    nfc_op_e    ops [6] = '{OP_RESET, OP_CACHE_PROG, OP_RAND_IN, OP_CONFIRM, OP_CACHE_NEXT,
                            OP_CACHE_LAST};
    logic [7:0] codes [6] = '{8'hff, 8'h15, 8'h85, 8'h10, 8'h31, 8'h3f};
    for (int i = 0; i < 6; i++) begin
      run_op(ops[i], PAGE_B, 12'h0, 12'h0, 1'b0);
      check("last command", codes[i], u_nfc_flash_model.last_cmd);
    end
    $display("test command codes finished");
  endtask : t_codes

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence after a six-cycle reset.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    mark_valid = 1'b0;
    mark_block = 10'h000;
    wr_allow = 1'b1;
    extra_busy = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_basic();
    t_prog_read();
    t_copy_erase();
    t_busy();
    t_codes();
    tally_and_finish();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #(25 * 40000);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    tally_and_finish();
  end
endmodule : tb_top

bind nfc_host nfc_host_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_nfc_host_assertions (
  .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .done(done), .err(err), .rd_valid(rd_valid), .rd_data(rd_data), .wr_allow(wr_allow),
  .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
  .wp_n(wp_n), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
  .data_pins_in(data_pins_in), .rb_in(rb_in));
